// >>> rtl/rdc_comparator.sv
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "rdc_cfg.svh"

module rdc_comparator (
    input  wire logic                 ref_clk,          // 200 MHz clock
    input  wire logic                 sys_rst,          // Sync reset, high
    input  wire rdc_pkg::rdc_bus_req_t bus_req,         // Register request
    output logic [31:0]               rd_data,          // Read data, next cycle
    input  wire rdc_pkg::rdc_conv_t   conv,             // Result path input
    output logic                      cmp_event_flag,   // Event flag level
    output logic [4:0]                monitored_input_id, // Input of last event
    output logic                      cmp_event_pulse,  // One cycle per event
    output logic                      irq               // Interrupt level
);

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    logic                  cmp_enable_r;
    logic                  cmp_irq_enable_r;
    rdc_pkg::rdc_evt_sel_t evt_sel_r;
    rdc_pkg::rdc_thresh_t  thresh_r;
    logic                  flag_r;
    logic [4:0]            id_r;
    logic [31:0]           last_result_r;
    logic [`RDC_IRQ_W-1:0] irq_stat_r;
    logic [`RDC_IRQ_W-1:0] irq_stat_nxt;
    logic [`RDC_IRQ_W-1:0] irq_en_r;
    logic [`RDC_IRQ_W-1:0] irq_en_nxt;
    logic [31:0]           rd_data_r;
    logic                  irq_r;
    logic                  pulse_r;

    logic                  hit;
    logic                  in_range;
    logic                  accept;
    logic                  ignored;
    logic                  event_now;
    logic                  wr_ctrl;
    logic                  wr_thresh;
    logic                  wr_clr;
    logic                  wr_en;
    logic                  rd_ctrl;
    logic                  disable_wr;
    logic                  flag_clear;
    logic [31:0]           ctrl_view;
    logic [31:0]           rd_mux;
    logic [`RDC_IRQ_W-1:0] irq_set;
    logic [`RDC_IRQ_W-1:0] irq_clr;

    // ------------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------------

    // Write selects per register and the read select for the control register
    assign wr_ctrl   = bus_req.wr && (bus_req.addr == `RDC_OFS_CTRL);
    assign wr_thresh = bus_req.wr && (bus_req.addr == `RDC_OFS_THRESH);
    assign wr_clr    = bus_req.wr && (bus_req.addr == `RDC_OFS_IRQ_CLR);
    assign wr_en     = bus_req.wr && (bus_req.addr == `RDC_OFS_IRQ_EN);
    assign rd_ctrl   = bus_req.rd && (bus_req.addr == `RDC_OFS_CTRL);

    // A control write with the enable bit low switches the unit off
    assign disable_wr = wr_ctrl && !bus_req.wdata[`RDC_BIT_ENABLE];

    // ------------------------------------------------------------------------
    // Comparison
    // ------------------------------------------------------------------------

    // Condition evaluation on the incoming result
    rdc_cmp_window u_window (
        .data (conv.data),
        .thr  (thresh_r),
        .sel  (evt_sel_r),
        .hit  (hit)
    );

    // Only inputs 0..31 are processed; higher numbers are dropped
    assign in_range = (conv.input_num[5] == 1'b0);
    assign accept   = conv.valid && cmp_enable_r && in_range;
    assign ignored  = conv.valid && cmp_enable_r && !in_range;

    // Comparator true on an accepted result
    assign event_now = accept && hit;

    // ------------------------------------------------------------------------
    // Control bits
    // ------------------------------------------------------------------------

    // Enable, interrupt enable and event selects
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cmp_enable_r     <= 1'b0;
            cmp_irq_enable_r <= 1'b0;
            evt_sel_r        <= '0;
        end else if (wr_ctrl) begin
            cmp_enable_r     <= bus_req.wdata[`RDC_BIT_ENABLE];
            cmp_irq_enable_r <= bus_req.wdata[`RDC_BIT_IRQ_EN];
            evt_sel_r        <= bus_req.wdata[`RDC_SEL_MSB:0];
        end
    end

    // Threshold pair
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            thresh_r.low_threshold  <= `RDC_THR_RST;
            thresh_r.high_threshold <= `RDC_THR_RST;
        end else if (wr_thresh) begin
            thresh_r.low_threshold  <= bus_req.wdata[`RDC_THR_LOW_LSB +: 16];
            thresh_r.high_threshold <= bus_req.wdata[`RDC_THR_HIGH_LSB +: 16];
        end
    end

    // ------------------------------------------------------------------------
    // Event flag and input identifier
    // ------------------------------------------------------------------------

    // Cleared by reading the identifier or by disabling; a new event wins
    assign flag_clear = rd_ctrl || disable_wr;

    // Sticky event flag
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            flag_r <= 1'b0;
        end else if (event_now) begin
            flag_r <= 1'b1;
        end else if (flag_clear) begin
            flag_r <= 1'b0;
        end
    end

    // Identifier of the input that caused the latest event
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            id_r <= `RDC_ID_RST;
        end else if (event_now) begin
            id_r <= conv.input_num[4:0];
        end
    end

    // Last accepted result, for software inspection
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            last_result_r <= 32'h0000_0000;
        end else if (accept) begin
            last_result_r <= conv.data;
        end
    end

    // One-cycle event marker
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pulse_r <= 1'b0;
        end else begin
            pulse_r <= event_now;
        end
    end

    // ------------------------------------------------------------------------
    // Interrupt status, clear and enable
    // ------------------------------------------------------------------------

    // Status sources: flag setting with the unit's own interrupt enable,
    // an ignored out-of-range result, and an event while flag still set
    assign irq_set[`RDC_IRQ_EVENT]   = event_now && cmp_irq_enable_r;
    assign irq_set[`RDC_IRQ_IGNORED] = ignored;
    assign irq_set[`RDC_IRQ_OVERRUN] = event_now && flag_r && !flag_clear;

    // Clear pattern from the write-only clear register
    assign irq_clr = wr_clr ? bus_req.wdata[`RDC_IRQ_W-1:0] : '0;

    // Set beats clear in the same cycle
    always_comb begin
        irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_set;
    end

    // Sticky status bits
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            irq_stat_r <= `RDC_IRQ_RST;
        end else begin
            irq_stat_r <= irq_stat_nxt;
        end
    end

    // Enable mask
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            irq_en_r <= `RDC_IRQ_RST;
        end else if (wr_en) begin
            irq_en_r <= bus_req.wdata[`RDC_IRQ_W-1:0];
        end
    end

    // Mask value after this cycle, so the pin follows a mask write at once
    assign irq_en_nxt = wr_en ? bus_req.wdata[`RDC_IRQ_W-1:0] : irq_en_r;

    // Registered interrupt level
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(irq_stat_nxt & irq_en_nxt);
        end
    end

    // ------------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------------

    // Control register image; upper bits stay zero
    always_comb begin
        ctrl_view                              = 32'h0000_0000;
        ctrl_view[`RDC_ID_MSB:`RDC_ID_LSB]     = id_r;
        ctrl_view[`RDC_BIT_ENABLE]             = cmp_enable_r;
        ctrl_view[`RDC_BIT_IRQ_EN]             = cmp_irq_enable_r;
        ctrl_view[`RDC_BIT_FLAG]               = flag_r;
        ctrl_view[`RDC_SEL_MSB:0]              = evt_sel_r;
    end

    // Read multiplexer; unmapped and write-only offsets read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (bus_req.addr)
            `RDC_OFS_CTRL: begin
                rd_mux = ctrl_view;
            end
            `RDC_OFS_THRESH: begin
                rd_mux = thresh_r;
            end
            `RDC_OFS_IRQ_STAT: begin
                rd_mux[`RDC_IRQ_W-1:0] = irq_stat_r;
            end
            `RDC_OFS_IRQ_EN: begin
                rd_mux[`RDC_IRQ_W-1:0] = irq_en_r;
            end
            `RDC_OFS_RESULT: begin
                rd_mux = last_result_r;
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    // Data stand only in the cycle after the read strobe
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rd_data_r <= 32'h0000_0000;
        end else if (bus_req.rd) begin
            rd_data_r <= rd_mux;
        end else begin
            rd_data_r <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------

    // All outputs come straight from flip-flops
    assign rd_data            = rd_data_r;
    assign cmp_event_flag     = flag_r;
    assign monitored_input_id = id_r;
    assign cmp_event_pulse    = pulse_r;
    assign irq                = irq_r;

endmodule : rdc_comparator

`default_nettype wire

// >>> rtl/rdc_cfg.svh
// Overview of operation
// - On an event, load the 5-bit code of the analog input that caused it.
// - Accept results only from inputs 0 to 31; ignore higher-numbered inputs.
// - Enable bit 7 switches the comparator on; writing 0 clears the event flag.
// - Interrupt enable bit 6 sets interrupt status bit 0 whenever the event flag sets; the irq pin also needs enable mask bit 0.
// - Read-only event flag bit 5 is set by hardware on comparator true.
// - Reading the input identifier field, or disabling, clears the event flag.
// - Five select bits choose which conditions make the comparator output true.
// - Between select bit 4: low < result < high, both strict.
// - At-or-above-high select bit 3: result >= high threshold.
// - Below-high select bit 2: result < high threshold.
// - Control bits 31 to 13 are unimplemented and read zero.
`ifndef RDC_CFG_SVH
`define RDC_CFG_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define RDC_ADDR_W        8
`define RDC_OFS_CTRL      8'h00
`define RDC_OFS_THRESH    8'h04
`define RDC_OFS_IRQ_STAT  8'h08
`define RDC_OFS_IRQ_CLR   8'h0C
`define RDC_OFS_IRQ_EN    8'h10
`define RDC_OFS_RESULT    8'h14

// ----------------------------------------------------------------------------
// Control and threshold register fields
// ----------------------------------------------------------------------------
`define RDC_BIT_ENABLE    7
`define RDC_BIT_IRQ_EN    6
`define RDC_BIT_FLAG      5
`define RDC_SEL_MSB       4
`define RDC_ID_LSB        8
`define RDC_ID_MSB        12
`define RDC_THR_LOW_LSB   0
`define RDC_THR_HIGH_LSB  16

// ----------------------------------------------------------------------------
// Interrupt status bits and reset values
// ----------------------------------------------------------------------------
`define RDC_IRQ_W         3
`define RDC_IRQ_EVENT     0
`define RDC_IRQ_IGNORED   1
`define RDC_IRQ_OVERRUN   2
`define RDC_CTRL_RST      8'h00
`define RDC_THR_RST       16'h0000
`define RDC_ID_RST        5'h00
`define RDC_IRQ_RST       3'h0

`endif

// >>> rtl/rdc_pkg.sv
package rdc_pkg;

    // One conversion result from the converter result path
    typedef struct packed {
        logic        valid;      // One-cycle strobe
        logic [5:0]  input_num;  // Analog input number, 0..63
        logic [31:0] data;       // Conversion result
    } rdc_conv_t;

    // Event-select bits, bit 4 down to bit 0
    typedef struct packed {
        logic between;
        logic at_or_above_high;
        logic below_high;
        logic at_or_above_low;
        logic below_low;
    } rdc_evt_sel_t;

    // Threshold pair
    typedef struct packed {
        logic [15:0] high_threshold;
        logic [15:0] low_threshold;
    } rdc_thresh_t;

    // Register port request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } rdc_bus_req_t;

endpackage : rdc_pkg

// >>> rtl/rdc_cmp_window.sv
`timescale 1ns/1ps
`default_nettype none

module rdc_cmp_window (
    input  wire logic [31:0]          data,   // Conversion result
    input  wire rdc_pkg::rdc_thresh_t thr,    // Low and high thresholds
    input  wire rdc_pkg::rdc_evt_sel_t sel,   // Enabled conditions
    output logic                      hit     // Comparator output
);

    logic [31:0] low_ext;
    logic [31:0] high_ext;
    logic        c_between;
    logic        c_hihi;
    logic        c_hilo;
    logic        c_lohi;
    logic        c_lolo;

    // Thresholds widened with zeros so the full result is compared
    assign low_ext  = {16'h0000, thr.low_threshold};
    assign high_ext = {16'h0000, thr.high_threshold};

    // Individual conditions
    assign c_between = (data > low_ext) && (data < high_ext);
    assign c_hihi    = (data >= high_ext);
    assign c_hilo    = (data < high_ext);
    assign c_lohi    = (data >= low_ext);
    assign c_lolo    = (data < low_ext);

    // Any selected condition makes the output true
    assign hit = (sel.between          & c_between) |
                 (sel.at_or_above_high & c_hihi)    |
                 (sel.below_high       & c_hilo)    |
                 (sel.at_or_above_low  & c_lohi)    |
                 (sel.below_low        & c_lolo);

endmodule : rdc_cmp_window

`default_nettype wire

// >>> dv/rdc_comparator_chk.sv
`timescale 1ns/1ps
`default_nettype none

module rdc_comparator_chk (
    input wire logic                  ref_clk,            // Clock
    input wire logic                  sys_rst,            // Sync reset
    input wire rdc_pkg::rdc_bus_req_t bus_req,            // Register request
    input wire logic [31:0]           rd_data,            // Read data
    input wire rdc_pkg::rdc_conv_t    conv,               // Result input
    input wire logic                  cmp_event_flag,     // Event flag
    input wire logic [4:0]            monitored_input_id, // Event input
    input wire logic                  cmp_event_pulse,    // Event pulse
    input wire logic                  irq                 // Interrupt
);
    // Single domain
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    // Event capture follows an accepted result
    id_load_a: assert property (cmp_event_pulse |-> $past(conv.valid) &&
        monitored_input_id == $past(conv.input_num[4:0])) else $error("wrong input id");
    ignore_high_a: assert property (conv.valid && conv.input_num[5] |=> !cmp_event_pulse)
        else $error("high input raised an event");
    flag_cause_a: assert property ($rose(cmp_event_flag) |-> $past(conv.valid) &&
        !$past(conv.input_num[5])) else $error("flag set without a result");
    pulse_flag_a: assert property (cmp_event_pulse |-> cmp_event_flag)
        else $error("event without flag");
    // Clearing causes
    read_clear_a: assert property (bus_req.rd && bus_req.addr == 8'h00 && !conv.valid
        |=> !cmp_event_flag) else $error("read left flag set");
    disable_clear_a: assert property (bus_req.wr && bus_req.addr == 8'h00 &&
        !bus_req.wdata[7] && !conv.valid |=> !cmp_event_flag [*2]) else $error("disable left flag");
    // Control image and reset state
    rd_ctrl_a: assert property ($past(bus_req.rd) && $past(bus_req.addr) == 8'h00 |->
        rd_data[31:13] == 19'h0 && rd_data[12:8] == $past(monitored_input_id) &&
        rd_data[5] == $past(cmp_event_flag)) else $error("bad control image");
    rst_zero_a: assert property ($past(sys_rst) |-> !cmp_event_flag && !irq &&
        monitored_input_id == 5'h00 && rd_data == 32'h0) else $error("outputs not zero after reset");
endmodule : rdc_comparator_chk

`default_nettype wire

// >>> dv/rdc_conv_src.sv
`timescale 1ns/1ps
`default_nettype none

module rdc_conv_src (
    input  wire logic             ref_clk, // Converter clock
    output var rdc_pkg::rdc_conv_t conv    // Result strobe and data
);
    // Idle before the first result
    initial conv = '0;

    // One result; idle lines show the inverse so stale values never match
    task automatic send(input logic [5:0] n, input logic [31:0] d, input int gap);
        conv <= '{valid: 1'b1, input_num: n, data: d};
        @(posedge ref_clk);
        if (gap > 0) begin
            conv <= '{valid: 1'b0, input_num: ~n, data: ~d};
            repeat (gap) @(posedge ref_clk);
        end
        #1;
    endtask : send
endmodule : rdc_conv_src

`default_nettype wire

// >>> dv/adc_result_digital_comparator_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) begin num_checks++; if ((a) !== (b)) begin err_count++; $display("[FAIL] %0t %s", $time, m); end end

module adc_result_digital_comparator_tb_top;
    logic                  ref_clk;            // Clock
    logic                  sys_rst;            // Reset
    rdc_pkg::rdc_bus_req_t bus_req;            // Register request
    logic [31:0]           rd_data;            // Read data
    rdc_pkg::rdc_conv_t    conv;               // Result input
    logic                  cmp_event_flag;     // Event flag
    logic [4:0]            monitored_input_id; // Event input
    logic                  cmp_event_pulse;    // Event pulse
    logic                  irq;                // Interrupt
    int                    err_count;          // Mismatches
    int                    num_checks;         // Comparisons
    logic [4:0]            last_id;            // Expected input id

    rdc_comparator uut (.ref_clk, .sys_rst, .bus_req, .rd_data, .conv, .cmp_event_flag,
        .monitored_input_id, .cmp_event_pulse, .irq);
    rdc_conv_src u_src (.ref_clk, .conv);

    // Clock
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------------
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        bus_req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge ref_clk);
        bus_req <= '0;
        #1;
    endtask : bus

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        `CHK(rd_data, exp, "read data")
    endtask : rd_chk

    // Enable with the given select bits, send a result, check and clear by reading
    task automatic try(input logic [4:0] sel, input logic [31:0] d, input logic [5:0] n, input logic hit);
        bus(1'b1, 8'h00, {24'h0, 3'b100, sel});
        u_src.send(n, d, 1);
        `CHK(cmp_event_flag, hit, "event flag")
        if (hit) last_id = n[4:0];
        `CHK(monitored_input_id, last_id, "input id")
        rd_chk(8'h00, {19'h0, last_id, 2'b10, hit, sel});
        `CHK(cmp_event_flag, 1'b0, "flag after read")
    endtask : try

    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : close_out

    // Hang guard
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_count++;
        close_out();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        sys_rst = 1'b1;
        bus_req = '0;
        last_id = 5'h00;
        repeat (16) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        #1;
        `CHK({cmp_event_flag, monitored_input_id, irq}, 7'h00, "reset outputs")
        rd_chk(8'h00, 32'h0);
        rd_chk(8'h04, 32'h0);
        bus(1'b1, 8'h04, 32'h0200_0100);
        rd_chk(8'h04, 32'h0200_0100);
        bus(1'b1, 8'h3C, 32'hFFFF_FFFF);
        rd_chk(8'h3C, 32'h0);
        $display("test reset done");
        try(5'h10, 32'h0000_0100, 6'd1, 1'b0);
        try(5'h10, 32'h0000_0101, 6'd2, 1'b1);
        try(5'h10, 32'h0000_01FF, 6'd3, 1'b1);
        try(5'h10, 32'h0000_0200, 6'd4, 1'b0);
        try(5'h10, 32'h1000_0150, 6'd5, 1'b0);
        try(5'h08, 32'h0000_01FF, 6'd6, 1'b0);
        try(5'h08, 32'h0000_0200, 6'd7, 1'b1);
        try(5'h08, 32'h1000_0000, 6'd14, 1'b1);
        try(5'h04, 32'h0000_01FF, 6'd31, 1'b1);
        try(5'h04, 32'h0000_0200, 6'd8, 1'b0);
        try(5'h02, 32'h0000_00FF, 6'd9, 1'b0);
        try(5'h02, 32'h0000_0100, 6'd10, 1'b1);
        try(5'h01, 32'h0000_00FF, 6'd0, 1'b1);
        try(5'h01, 32'h0000_0100, 6'd11, 1'b0);
        try(5'h03, 32'h0000_0000, 6'd12, 1'b1);
        try(5'h00, 32'h0000_0150, 6'd13, 1'b0);
        try(5'h01, 32'h0000_0000, 6'd32, 1'b0);
        try(5'h01, 32'h0000_0000, 6'd63, 1'b0);
        rd_chk(8'h08, 32'h2);
        rd_chk(8'h14, 32'h0000_0150);
        $display("test selects done");
        bus(1'b1, 8'h0C, 32'h7);
        bus(1'b1, 8'h10, 32'h1);
        bus(1'b1, 8'h00, 32'hC1);
        u_src.send(6'd20, 32'h0, 1);
        `CHK(irq, 1'b1, "irq on event")
        rd_chk(8'h08, 32'h1);
        bus(1'b1, 8'h0C, 32'h1);
        `CHK(irq, 1'b0, "irq after clear")
        bus(1'b1, 8'h10, 32'h0);
        u_src.send(6'd21, 32'h0, 0);
        u_src.send(6'd22, 32'h0, 1);
        `CHK(irq, 1'b0, "masked irq")
        `CHK(monitored_input_id, 5'd22, "back to back id")
        rd_chk(8'h08, 32'h5);
        bus(1'b1, 8'h00, 32'h81);
        bus(1'b1, 8'h0C, 32'h7);
        bus(1'b1, 8'h10, 32'h7);
        rd_chk(8'h00, 32'h0000_16A1);
        u_src.send(6'd23, 32'h0, 1);
        `CHK(irq, 1'b0, "irq with bit 6 low")
        rd_chk(8'h08, 32'h0);
        rd_chk(8'h0C, 32'h0);
        $display("test interrupt done");
        `CHK(cmp_event_flag, 1'b1, "flag before disable")
        bus(1'b1, 8'h00, 32'h01);
        `CHK(cmp_event_flag, 1'b0, "flag after disable")
        u_src.send(6'd24, 32'h0, 1);
        `CHK({cmp_event_flag, monitored_input_id}, {1'b0, 5'd23}, "disabled result")
        bus(1'b1, 8'h00, 32'hFFFF_FF3F);
        rd_chk(8'h00, 32'h0000_171F);
        $display("test disable done");
        close_out();
    end
endmodule : adc_result_digital_comparator_tb_top

bind rdc_comparator rdc_comparator_chk u_chk (.ref_clk, .sys_rst, .bus_req, .rd_data, .conv,
    .cmp_event_flag, .monitored_input_id, .cmp_event_pulse, .irq);

`default_nettype wire
